// >>> rtl/fls_cfg.svh
`ifndef FLS_CFG_SVH
`define FLS_CFG_SVH

// clock period of clk_sys in ns (125 MHz)
`define FLS_CLK_NS       8
// one character at 600 characters per minute (100 words per minute)
`define FLS_CHAR_NS      100000000
// character length and stop length in hundredths of a unit
`define FLS_CHAR_X100    742
`define FLS_STOP_X100    142
`define FLS_DATA_BITS    5
`define FLS_CNT_W        22
`define FLS_FIFO_DEPTH   8
`define FLS_MARK         1'b1
`define FLS_SPACE        1'b0
// element index of the stop element (start is 0, data 1..5)
`define FLS_STOP_ELEM    3'h6
// vote points sit unit/16 either side of the element centre
`define FLS_WIN_SHIFT    4
// nominal unit interval in clk_sys cycles, rounded down
`define FLS_UNIT_CYCLES  (((`FLS_CHAR_NS) / (`FLS_CLK_NS)) * 100 / `FLS_CHAR_X100)

`endif

// >>> rtl/fls_pkg.sv
`include "fls_cfg.svh"

package fls_pkg;
	typedef enum logic [0:0] {
		RX_IDLE,
		RX_RUN
	} fls_rx_st_t;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_STOP
	} fls_tx_st_t;

	typedef logic [`FLS_CNT_W-1:0]     fls_cnt_t;
	typedef logic [`FLS_DATA_BITS-1:0] fls_char_t;
endpackage

// >>> rtl/fls_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module fls_fifo #(
	parameter int W     = 5,
	parameter int DEPTH = 8
) (
	input  wire logic         clk_sys,   // system clock
	input  wire logic         rst_n,     // async reset, active low
	input  wire logic [W-1:0] in_data,   // word to store
	input  wire logic         in_valid,  // in_data offered
	output logic              in_ready,  // room for a word
	output logic [W-1:0]      out_data,  // oldest word
	output logic              out_valid, // out_data holds a word
	input  wire logic         out_ready  // consumer takes out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    in_rdy;
		logic                    out_vld;
		logic [W-1:0]            out_dat;
	} fls_fifo_st_t;

	localparam fls_fifo_st_t ST_RST = '{
		mem: '0, wp: '0, rp: '0, cnt: '0,
		in_rdy: 1'b1, out_vld: 1'b0, out_dat: '0
	};

	fls_fifo_st_t st_reg;
	fls_fifo_st_t st_next;

	always_comb begin
		logic push;
		logic take;
		logic load;
		push = in_valid && st_reg.in_rdy;
		take = st_reg.out_vld && out_ready;
		load = (st_reg.cnt != '0) && (!st_reg.out_vld || take);
		st_next = st_reg;
		if (take) begin
			st_next.out_vld = 1'b0;
		end
		// output word comes from a register, refilled as it drains
		if (load) begin
			st_next.out_dat = st_reg.mem[st_reg.rp];
			st_next.out_vld = 1'b1;
			st_next.rp      = st_reg.rp + 1'b1;
		end
		if (push) begin
			st_next.mem[st_reg.wp] = in_data;
			st_next.wp             = st_reg.wp + 1'b1;
		end
		st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(load);
		// registered ready so the top sees it straight from a flop
		st_next.in_rdy = (st_next.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign in_ready  = st_reg.in_rdy;
	assign out_data  = st_reg.out_dat;
	assign out_valid = st_reg.out_vld;
endmodule

`default_nettype wire

// >>> rtl/fls_link.sv
// Behaviour
// - every frame opens with one space start
// - five intelligence elements follow the start
// - mark stop lasts 1.42 units
// - transmitter always adds start and stop
// - receiver starts on mark-to-space edge
// - timing restarts at every start edge
// - samples timed from the start edge
// - receiver idles before incoming stop ends
// - decide within short window per element
// - mark is one, space is zero
// - distortion measured against start transition
// - unit interval matches 100 wpm line
`timescale 1ns/10ps
`default_nettype none
`include "fls_cfg.svh"

module fls_link #(
	parameter int UNIT_CYCLES = `FLS_UNIT_CYCLES
) (
	input  wire logic                      clk_sys,      // system clock
	input  wire logic                      rst_n,        // async reset
	input  wire logic [`FLS_CNT_W-1:0]     unit_div,     // unit, 0 = default
	input  wire logic                      rx_line,      // line in, 1 = mark
	output logic [`FLS_DATA_BITS-1:0]      rx_data,      // received char
	output logic                           rx_valid,     // char pulse
	output logic                           rx_frame_err, // stop was space
	output logic [`FLS_CNT_W-1:0]          rx_dist,      // worst shift
	input  wire logic [`FLS_DATA_BITS-1:0] tx_data,      // char to send
	input  wire logic                      tx_valid,     // tx_data offered
	output logic                           tx_ready,     // queue has room
	output logic                           tx_line,      // line out
	output logic                           tx_busy       // frame on line
);
	typedef struct packed {
		logic                 rx_s0;
		logic                 rx_s1;
		logic                 rx_prev;
		fls_pkg::fls_rx_st_t  rx_st;
		fls_pkg::fls_cnt_t    rx_ph;
		logic [2:0]           rx_elem;
		logic [1:0]           rx_votes;
		fls_pkg::fls_char_t   rx_shift;
		fls_pkg::fls_cnt_t    dist_cur;
		fls_pkg::fls_char_t   rx_dat;
		logic                 rx_vld;
		logic                 rx_err;
		fls_pkg::fls_cnt_t    rx_dst;
		fls_pkg::fls_cnt_t    unit;
		fls_pkg::fls_cnt_t    stop_len;
		fls_pkg::fls_tx_st_t  tx_st;
		fls_pkg::fls_cnt_t    tx_ph;
		logic [2:0]           tx_bit;
		fls_pkg::fls_char_t   tx_shift;
		logic                 tx_out;
		logic                 tx_bsy;
	} fls_link_st_t;

	localparam fls_link_st_t ST_RST = '{
		rx_s0: `FLS_MARK, rx_s1: `FLS_MARK, rx_prev: `FLS_MARK,
		rx_st: fls_pkg::RX_IDLE, rx_ph: '0, rx_elem: '0,
		rx_votes: '0, rx_shift: '0, dist_cur: '0, rx_dat: '0,
		rx_vld: 1'b0, rx_err: 1'b0, rx_dst: '0,
		unit: fls_pkg::fls_cnt_t'(UNIT_CYCLES),
		stop_len: fls_pkg::fls_cnt_t'(UNIT_CYCLES),
		tx_st: fls_pkg::TX_IDLE, tx_ph: '0, tx_bit: '0,
		tx_shift: '0, tx_out: `FLS_MARK, tx_bsy: 1'b0
	};

	fls_link_st_t                st_reg;
	fls_link_st_t                st_next;
	logic [`FLS_DATA_BITS-1:0]   q_data;
	logic                        q_valid;
	logic                        q_take;

	fls_fifo #(
		.W     (`FLS_DATA_BITS),
		.DEPTH (`FLS_FIFO_DEPTH)
	) u_txq (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (q_data),
		.out_valid (q_valid),
		.out_ready (q_take)
	);

	// distance of a phase to the nearest element boundary
	function automatic fls_pkg::fls_cnt_t edge_disp(
		input fls_pkg::fls_cnt_t ph,
		input fls_pkg::fls_cnt_t unit
	);
		fls_pkg::fls_cnt_t half;
		half = unit >> 1;
		if (ph < half) begin
			edge_disp = ph;
		end else begin
			edge_disp = unit - ph;
		end
	endfunction

	assign q_take = (st_reg.tx_st == fls_pkg::TX_IDLE) && q_valid;

	always_comb begin
		logic [`FLS_CNT_W+7:0] stop_wide;
		fls_pkg::fls_cnt_t     half;
		fls_pkg::fls_cnt_t     win;
		fls_pkg::fls_cnt_t     disp;
		logic                  bit_val;
		logic                  fall;
		st_next = st_reg;
		stop_wide = '0;
		half = st_reg.unit >> 1;
		win = st_reg.unit >> `FLS_WIN_SHIFT;
		disp = '0;
		bit_val = 1'b0;

		if (unit_div == '0) begin
			st_next.unit = fls_pkg::fls_cnt_t'(UNIT_CYCLES);
		end else begin
			st_next.unit = unit_div;
		end
		stop_wide = (`FLS_CNT_W+8)'(
			({8'h00, st_reg.unit} * `FLS_STOP_X100) / 100);
		st_next.stop_len = stop_wide[`FLS_CNT_W-1:0];

		// two flops before the line is looked at
		st_next.rx_s0 = rx_line;
		st_next.rx_s1 = st_reg.rx_s0;
		st_next.rx_prev = st_reg.rx_s1;
		fall = st_reg.rx_prev && !st_reg.rx_s1;
		st_next.rx_vld = 1'b0;

		unique case (st_reg.rx_st)
			fls_pkg::RX_IDLE: begin
				if (fall) begin
					st_next.rx_st = fls_pkg::RX_RUN;
					// the edge cycle is phase 0, so this one is 1
					st_next.rx_ph = fls_pkg::fls_cnt_t'(1);
					st_next.rx_elem = '0;
					st_next.rx_votes = '0;
					st_next.dist_cur = '0;
				end
			end
			fls_pkg::RX_RUN: begin
				if (st_reg.rx_ph == st_reg.unit - 1'b1) begin
					st_next.rx_ph = '0;
				end else begin
					st_next.rx_ph = st_reg.rx_ph + 1'b1;
				end
				// worst edge shift vs start edge
				if (st_reg.rx_s1 != st_reg.rx_prev) begin
					disp = edge_disp(st_reg.rx_ph, st_reg.unit);
					if (disp > st_reg.dist_cur) begin
						st_next.dist_cur = disp;
					end
				end
				if (st_reg.rx_ph == half - win ||
				    st_reg.rx_ph == half) begin
					st_next.rx_votes = st_reg.rx_votes +
						{1'b0, st_reg.rx_s1};
				end
				if (st_reg.rx_ph == half + win) begin
					bit_val = (st_reg.rx_votes +
						{1'b0, st_reg.rx_s1}) >= 2'h2;
					st_next.rx_votes = '0;
					st_next.rx_elem = st_reg.rx_elem + 1'b1;
					if (st_reg.rx_elem == 3'h0) begin
						if (bit_val == `FLS_MARK) begin
							st_next.rx_st = fls_pkg::RX_IDLE;
						end
					end else if (st_reg.rx_elem ==
					             `FLS_STOP_ELEM) begin
						st_next.rx_st = fls_pkg::RX_IDLE;
						st_next.rx_dat = st_reg.rx_shift;
						st_next.rx_vld = 1'b1;
						st_next.rx_err = (bit_val != `FLS_MARK);
						st_next.rx_dst = st_next.dist_cur;
					end else begin
						// mark gives one, first bit low
						st_next.rx_shift = {bit_val,
							st_reg.rx_shift[`FLS_DATA_BITS-1:1]};
					end
				end
			end
		endcase

		unique case (st_reg.tx_st)
			fls_pkg::TX_IDLE: begin
				st_next.tx_out = `FLS_MARK;
				st_next.tx_bsy = 1'b0;
				if (q_valid) begin
					st_next.tx_shift = q_data;
					st_next.tx_st = fls_pkg::TX_START;
					st_next.tx_ph = '0;
					st_next.tx_out = `FLS_SPACE;
					st_next.tx_bsy = 1'b1;
				end
			end
			fls_pkg::TX_START: begin
				st_next.tx_ph = st_reg.tx_ph + 1'b1;
				if (st_reg.tx_ph == st_reg.unit - 1'b1) begin
					st_next.tx_ph = '0;
					st_next.tx_bit = '0;
					st_next.tx_st = fls_pkg::TX_DATA;
					st_next.tx_out = st_reg.tx_shift[0];
				end
			end
			fls_pkg::TX_DATA: begin
				st_next.tx_ph = st_reg.tx_ph + 1'b1;
				if (st_reg.tx_ph == st_reg.unit - 1'b1) begin
					st_next.tx_ph = '0;
					st_next.tx_bit = st_reg.tx_bit + 1'b1;
					st_next.tx_shift = st_reg.tx_shift >> 1;
					if (st_reg.tx_bit == 3'h4) begin
						st_next.tx_st = fls_pkg::TX_STOP;
						st_next.tx_out = `FLS_MARK;
					end else begin
						st_next.tx_out = st_reg.tx_shift[1];
					end
				end
			end
			fls_pkg::TX_STOP: begin
				st_next.tx_ph = st_reg.tx_ph + 1'b1;
				if (st_reg.tx_ph == st_reg.stop_len - 1'b1) begin
					st_next.tx_ph = '0;
					st_next.tx_st = fls_pkg::TX_IDLE;
					st_next.tx_bsy = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rx_data      = st_reg.rx_dat;
	assign rx_valid     = st_reg.rx_vld;
	assign rx_frame_err = st_reg.rx_err;
	assign rx_dist      = st_reg.rx_dst;
	assign tx_line      = st_reg.tx_out;
	assign tx_busy      = st_reg.tx_bsy;
endmodule

`default_nettype wire

// >>> sim/fls_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module fls_link_assertions #(
	parameter int UNIT_CYCLES = 64
) (
	input wire logic        clk_sys,      // clock
	input wire logic        rst_n,        // reset
	input wire logic [21:0] unit_div,     // unit
	input wire logic        rx_line,      // line in
	input wire logic [4:0]  rx_data,      // char in
	input wire logic        rx_valid,     // char pulse
	input wire logic        rx_frame_err, // stop error
	input wire logic [21:0] rx_dist,      // distortion
	input wire logic [4:0]  tx_data,      // char out
	input wire logic        tx_valid,     // offer
	input wire logic        tx_ready,     // room
	input wire logic        tx_line,      // line out
	input wire logic        tx_busy       // frame on line
);
	int   u;
	int   stp;
	logic line_q;
	int   run_reg;
	int   bsy_reg;

	assign u = (unit_div == '0) ? UNIT_CYCLES : int'(unit_div);
	assign stp = u * 142 / 100;

	// run_reg is the length of the level run before a change
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			line_q  <= 1'h1;
			run_reg <= 0;
			bsy_reg <= 0;
		end else begin
			line_q  <= tx_line;
			run_reg <= (tx_line != line_q) ? 1 : run_reg + 1;
			bsy_reg <= tx_busy ? bsy_reg + 1 : 0;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_IDLE_MARK: assert property (
		!tx_busy |-> tx_line) else $error("line not mark at idle");
	AST_START_SPACE: assert property (
		$rose(tx_busy) |-> !tx_line [*2]) else $error("no space start");
	AST_RISE_IN_FRAME: assert property (
		tx_line && !line_q |-> tx_busy) else $error("rise outside frame");
	AST_SPACE_LEN: assert property (
		tx_line && !line_q |-> run_reg % u == 0)
		else $error("space run not whole units");
	AST_MARK_LEN: assert property (
		!tx_line && line_q && $past(tx_busy) |-> run_reg % u == 0)
		else $error("mark run not whole units");
	AST_STOP_LEN: assert property (
		$fell(tx_busy) |-> run_reg >= stp) else $error("stop too short");
	AST_FRAME_LEN: assert property (
		$fell(tx_busy) |-> bsy_reg inside {[6 * u + stp : 6 * u + stp + 1]})
		else $error("frame length wrong");
	AST_RX_PULSE: assert property (
		rx_valid |=> !rx_valid) else $error("rx_valid longer than one");
	AST_RX_HOLD: assert property (
		!rx_valid |-> $stable(rx_data)) else $error("rx_data moved");
	AST_RX_STOP: assert property (
		rx_valid |-> rx_frame_err == !$past(rx_line, 3))
		else $error("frame error wrong");
endmodule

bind fls_link fls_link_assertions #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .unit_div(unit_div),
	.rx_line(rx_line), .rx_data(rx_data), .rx_valid(rx_valid),
	.rx_frame_err(rx_frame_err), .rx_dist(rx_dist), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_line(tx_line),
	.tx_busy(tx_busy));
`default_nettype wire

// >>> sim/fls_remote.sv
`timescale 1ns/10ps
`default_nettype none
module fls_remote #(
	parameter int U = 64
) (
	input wire logic clk_sys, // clock
	input wire logic tx_line, // line from link
	output logic     rx_line  // line to link
);
	logic [5:0] got[$];

	initial rx_line = 1'h1;

	task automatic send(input logic [4:0] ch, input logic stp);
		logic [6:0] f;
		f = {stp, ch, 1'h0};
		for (int i = 0; i < 7; i++) begin
			@(negedge clk_sys);
			rx_line = f[i];
			repeat ((i == 6) ? U * 142 / 100 - 1 : U - 1) @(negedge clk_sys);
		end
		@(negedge clk_sys);
		rx_line = 1'h1;
	endtask

	// short space that is not a start
	task automatic blip(input int n);
		@(negedge clk_sys);
		rx_line = 1'h0;
		repeat (n) @(negedge clk_sys);
		rx_line = 1'h1;
	endtask

	always begin
		logic [6:0] f;
		@(negedge tx_line);
		repeat (U / 2) @(negedge clk_sys);
		for (int i = 0; i < 7; i++) begin
			f[i] = tx_line;
			if (i < 6) repeat (U) @(negedge clk_sys);
		end
		got.push_back({f[0] | ~f[6], f[5:1]});
	end
endmodule
`default_nettype wire

// >>> sim/tb_five_level_start_stop_link.sv
`timescale 1ns/10ps
`default_nettype none
module tb_five_level_start_stop_link;
	localparam int U = 64;
	logic        clk_sys = 1'h0;
	logic        rst_n = 1'h0;
	logic [21:0] unit_div = 22'h00_0040;
	logic        rx_line;
	logic [4:0]  rx_data;
	logic        rx_valid;
	logic        rx_frame_err;
	logic [21:0] rx_dist;
	logic [4:0]  tx_data = 5'h00;
	logic        tx_valid = 1'h0;
	logic        tx_ready;
	logic        tx_line;
	logic        tx_busy;
	int          mismatches = 0;
	int          comparisons = 0;
	logic [31:0] seed = 32'h0795_8132;
	logic [27:0] rxq[$];
	logic [5:0]  exq[$];
	logic [4:0]  ch;
	logic        took;
	int          n;

	always #4 clk_sys = ~clk_sys;

	fls_link #(.UNIT_CYCLES(100)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .unit_div(unit_div),
		.rx_line(rx_line), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_frame_err(rx_frame_err), .rx_dist(rx_dist), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_line(tx_line),
		.tx_busy(tx_busy));
	fls_remote #(.U(U)) far (
		.clk_sys(clk_sys), .tx_line(tx_line), .rx_line(rx_line));

	always @(posedge clk_sys)
		if (rx_valid === 1'h1) rxq.push_back({rx_dist, rx_frame_err, rx_data});

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string what, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (e !== g) begin
			mismatches++;
			$display("CHECK FAILED %s exp %0h got %0h", what, e, g);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// frames follow one another one mark cycle apart; result lands in the stop
	task automatic rx_one(input logic [4:0] c, input logic stp);
		far.send(c, stp);
		check("rx count", 1, rxq.size());
		if (rxq.size() > 0)
			check("rx word", {22'h00_0000, ~stp, c}, rxq.pop_front());
	endtask

	initial begin
		repeat (3) @(negedge clk_sys);
		rst_n = 1'h1;
		repeat (4) @(negedge clk_sys);
		check("tx idle", 3'h6, {tx_line, tx_ready, tx_busy});
		for (int i = 0; i < 10; i++) begin
			ch = (i < 2) ? {5{i[0]}} : 5'(rnd());
			rx_one(ch, 1'h1);
		end
		rx_one(5'h15, 1'h0);
		far.blip(U / 4);
		repeat (8 * U) @(negedge clk_sys);
		check("false start", 0, rxq.size());
		rx_one(5'h0a, 1'h1);
		took = 1'h0;
		for (int i = 0; i < 16; i++) begin
			@(negedge clk_sys);
			if (took) exq.push_back({1'h0, tx_data});
			if (took) tx_data = 5'(rnd());
			tx_valid = 1'h1;
			took = (tx_ready === 1'h1);
		end
		@(negedge clk_sys);
		if (took) exq.push_back({1'h0, tx_data});
		tx_valid = 1'h0;
		check("refused", 1, exq.size() < 16);
		n = 0;
		while (far.got.size() < exq.size() && n < 16 * 600) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 16 * 600) begin
			mismatches++;
			finish_test();
		end
		repeat (2 * U) @(negedge clk_sys);
		check("tx count", exq.size(), far.got.size());
		foreach (exq[i])
			check("tx word", exq[i], far.got[i]);
		finish_test();
	end
endmodule
`default_nettype wire
